// *** pkg/ddr_phy_lane_pkg.sv ***
`default_nettype none
package ddr_phy_lane_pkg;
  // ==========================================================
  // Instance counts and address width
  localparam int IMP_INST = 4;
  localparam int LANE_NUM = 9;
  localparam int RANKS = 4;
  localparam int ADDR_W = 8;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ZQ_MAIN_OFS = 8'h00;
  localparam logic [7:0] ZQ_DETAIL_OFS = 8'h04;
  localparam logic [7:0] ZQ_STRIDE = 8'h08;
  localparam logic [7:0] LANE_OFS = 8'h20;
  localparam logic [7:0] GLOB_OFS = 8'h44;
  // ==========================================================
  // Impedance status fields
  localparam int ZQ_DONE_BIT = 31;
  localparam int ZQ_FAULT_BIT = 30;
  localparam int CODE_W = 28;
  localparam int SEL_W = 7;
  localparam int TPU_LSB = 21;
  localparam int TPD_LSB = 14;
  localparam int DPU_LSB = 7;
  localparam int DPD_LSB = 0;
  localparam int DETAIL_W = 8;
  localparam logic [31:0] ZQ_MAIN_RST = 32'h0000_014A;
  localparam logic [1:0] CAL_OK = 2'h0;
  localparam logic [1:0] CAL_OVERFLOW = 2'h1;
  localparam logic [1:0] CAL_UNDERFLOW = 2'h2;
  localparam logic [1:0] CAL_BUSY = 2'h3;
  // ==========================================================
  // Byte lane general configuration fields
  localparam int SKIP_BIT = 31;
  localparam int TRACK_BIT = 30;
  localparam int WLM_LSB = 26;
  localparam int BYP_BIT = 19;
  localparam int FAST_BIT = 18;
  localparam int PD_BIT = 17;
  localparam int RST_BIT = 16;
  localparam int OEO_LSB = 14;
  localparam int EARLY_BIT = 13;
  localparam int HOLD_LSB = 11;
  localparam int DQDYN_BIT = 10;
  localparam int DQSDYN_BIT = 9;
  localparam int STRB_LSB = 7;
  localparam int RXCELL_BIT = 6;
  localparam int RXPD_BIT = 5;
  localparam int DRVPD_BIT = 4;
  localparam int CMOS_BIT = 3;
  localparam int DATA_TERMINATION_ENABLE_BIT = 2;
  localparam int STROBE_TERMINATION_ENABLE_BIT = 1;
  localparam int EN_BIT = 0;
  localparam logic [31:0] GCR_RST = 32'h7C00_0E81;
  localparam logic [31:0] GCR_WMASK = 32'hFC0F_FFFF;
  localparam logic [1:0] OEO_FOLLOW = 2'h0;
  localparam logic [1:0] OEO_OUT = 2'h1;
  localparam logic [1:0] OEO_IN = 2'h2;
  localparam logic [1:0] STRB_LOW = 2'h0;
  localparam logic [1:0] STRB_NORM = 2'h1;
  localparam logic [1:0] STRB_INV = 2'h2;
  localparam logic [1:0] STRB_HIGH = 2'h3;
  // ==========================================================
  // Global PLL and master delay line tracking control fields
  localparam int GLOB_W = 4;
  localparam int G_BYP_BIT = 0;
  localparam int G_PD_BIT = 1;
  localparam int G_RST_BIT = 2;
  localparam int G_MDL_BIT = 3;
  localparam logic [3:0] GLOB_RST = 4'h8;
  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** sim/ddr_phy_lane_cfg_status_tb.sv ***
`default_nettype none
module ddr_phy_lane_cfg_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // Signals
  logic clk_i, rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] imp_cal_complete_i = 4'hA, imp_cal_fault_i = 4'h6;
  logic [3:0][27:0] imp_code_current_i;
  logic [3:0][7:0] imp_cal_state_i;
  logic [3:0][6:0] term_pullup_sel_o, term_pulldown_sel_o, drv_pullup_sel_o, drv_pulldown_sel_o;
  logic phy_init_done_i = 1'b0, rd_ahead_i = 1'b0, wr_oe_i = 1'b0, wr_strobe_phase_i = 1'b0;
  logic [8:0][3:0] wl_resp_i, wl_resp_used_o, wl_rank_done_o;
  logic [8:0] lane_cal_start_o, master_delay_line_track_o, lane_pll_bypass_o, lane_pll_fast_lock_o;
  logic [8:0] lane_pll_powerdown_o, lane_pll_reset_o, dq_oe_o, dqs_o, dqs_n_o, dqs_oe_o;
  logic [8:0] dq_odt_o, dqs_odt_o, strobe_rx_cell_powerdown_o, lane_receiver_powerdown_o;
  logic [8:0] lane_driver_powerdown_o, lane_cmos_io_select_o, byte_lane_enable_o;
  logic [31:0] rd, ex;
  int bad_count = 0, samples_checked = 0;
  // =====
  // Design and memory side
  ddr_phy_lane_regs u_dut (.clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .imp_cal_complete_i, .imp_cal_fault_i, .imp_code_current_i,
    .imp_cal_state_i, .term_pullup_sel_o, .term_pulldown_sel_o, .drv_pullup_sel_o,
    .drv_pulldown_sel_o, .phy_init_done_i, .rd_ahead_i, .wr_oe_i, .wr_strobe_phase_i, .wl_resp_i,
    .lane_cal_start_o, .master_delay_line_track_o, .wl_resp_used_o, .wl_rank_done_o,
    .lane_pll_bypass_o, .lane_pll_fast_lock_o, .lane_pll_powerdown_o, .lane_pll_reset_o, .dq_oe_o,
    .dqs_o, .dqs_n_o, .dqs_oe_o, .dq_odt_o, .dqs_odt_o, .strobe_rx_cell_powerdown_o,
    .lane_receiver_powerdown_o, .lane_driver_powerdown_o, .lane_cmos_io_select_o,
    .byte_lane_enable_o);
  ddr_sdram_model u_mem (.clk_i, .rst_n_i, .wl_resp_o(wl_resp_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) wr_strobe_phase_i <= ~wr_strobe_phase_i;
  // =====
  // Tasks
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge clk_i);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_i);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    if (!b) chk("write answer", 36'h1, 36'h0);
    if (!b) wrap_up();
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    logic ar, v;
    v = 1'b0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !v; n++) begin
      @(negedge clk_i);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk_i);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
    end
    if (!v) chk("read answer", 36'h1, 36'h0);
    if (!v) wrap_up();
    chk(nm, 36'(e), 36'(rd));
    chk(nm, 36'(er), 36'(rs));
  endtask
  function automatic logic [7:0] la(input int n);
    return ddr_phy_lane_pkg::LANE_OFS + 8'(4 * n);
  endfunction
  // =====
  // Tests
  initial begin
    for (int n = 0; n < 4; n++) begin
      imp_code_current_i[n] = {7'h11 + 7'(n), 7'h22 + 7'(n), 7'h33 + 7'(n), 7'h44 + 7'(n)};
      imp_cal_state_i[n] = {2'(n), 2'(n + 1), 2'(n + 2), 2'(n + 3)};
    end
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rc("lane0 cfg", la(0), ddr_phy_lane_pkg::GCR_RST);
    rc("lane8 cfg", la(8), ddr_phy_lane_pkg::GCR_RST);
    @(negedge clk_i);
    chk("enable", 36'h1FF, 36'(byte_lane_enable_o));
    chk("track", 36'h1FF, 36'(master_delay_line_track_o));
    chk("rank done", 36'h0, 36'(wl_rank_done_o));
    $display("Reset test done");
    for (int n = 0; n < 4; n++) begin
      ex = {imp_cal_complete_i[n], imp_cal_fault_i[n], 2'b00, imp_code_current_i[n]};
      rc("main", ddr_phy_lane_pkg::ZQ_STRIDE * 8'(n), ex);
      rc("detail", 8'h04 + 8'h08 * 8'(n), {24'h00_0000, imp_cal_state_i[n]});
      chk("sel", 36'(imp_code_current_i[n]), 36'({term_pullup_sel_o[n], term_pulldown_sel_o[n],
          drv_pullup_sel_o[n], drv_pulldown_sel_o[n]}));
    end
    wr(8'h00, 32'hFFFF_FFFF, rs);
    chk("status write", 36'h0, 36'(rs));
    rc("status kept", 8'h00, {4'h0, imp_code_current_i[0]});
    wr(8'h80, 32'hFFFF_FFFF, rs);
    chk("unmapped write", 36'(ddr_phy_lane_pkg::RESP_SLVERR), 36'(rs));
    rc("unmapped read", 8'h80, 32'h0000_0000, ddr_phy_lane_pkg::RESP_SLVERR);
    $display("Status test done");
    wr(la(4), 32'hFFFF_FFFF, rs);
    rc("lane4 cfg", la(4), ddr_phy_lane_pkg::GCR_WMASK);
    repeat (2) @(negedge clk_i);
    chk("lane4 pll", 36'hF, 36'({lane_pll_bypass_o[4], lane_pll_fast_lock_o[4],
        lane_pll_powerdown_o[4], lane_pll_reset_o[4]}));
    chk("lane4 static", 36'hF, 36'({strobe_rx_cell_powerdown_o[4], lane_receiver_powerdown_o[4],
        lane_driver_powerdown_o[4], lane_cmos_io_select_o[4]}));
    chk("lane3 pll", 36'h0, 36'(lane_pll_bypass_o[3]));
    wr(la(4), 32'h0000_0000, rs);
    wr(ddr_phy_lane_pkg::GLOB_OFS, 32'h0000_0007, rs);
    @(negedge clk_i);
    chk("global pll", 36'h7FF_FFFF, 36'({lane_pll_bypass_o, lane_pll_powerdown_o,
        lane_pll_reset_o}));
    chk("track off", 36'h0, 36'(master_delay_line_track_o));
    wr(ddr_phy_lane_pkg::GLOB_OFS, 32'h0000_0008, rs);
    wr(la(2), 32'h1400_0001, rs);
    @(negedge clk_i);
    chk("pll free", 36'h0, 36'({lane_pll_bypass_o, lane_pll_reset_o}));
    chk("rank done", 36'hA, 36'(wl_rank_done_o[2]));
    chk("rank used", 36'(wl_resp_i[2] & 4'h5), 36'(wl_resp_used_o[2]));
    wr(la(1), 32'h8000_0001, rs);
    @(posedge clk_i);
    phy_init_done_i <= 1'b1;
    @(posedge clk_i);
    phy_init_done_i <= 1'b0;
    @(negedge clk_i);
    chk("cal start", 36'h1ED, 36'(lane_cal_start_o));
    @(negedge clk_i);
    chk("cal end", 36'h0, 36'(lane_cal_start_o));
    $display("Lane test done");
    for (int m = 0; m < 4; m++) begin
      wr(la(0), ddr_phy_lane_pkg::GCR_RST | (32'(m) << 14), rs);
      for (int o = 0; o < 2; o++) begin
        @(posedge clk_i);
        wr_oe_i <= o[0];
        repeat (3) @(negedge clk_i);
        ex = (m == 1 || (m != 2 && o == 1)) ? 32'h0000_0001 : 32'h0000_0000;
        chk("dq oe", 36'(ex), 36'(dq_oe_o[0]));
        chk("dqs oe", 36'(ex), 36'(dqs_oe_o[0]));
      end
    end
    for (int s = 0; s < 4; s++) begin
      wr(la(0), 32'h7C00_4807 | (32'(s) << 7), rs);
      repeat (2) @(negedge clk_i);
      ex = 32'((s == 3) | ((s == 1) & !wr_strobe_phase_i) | ((s == 2) & wr_strobe_phase_i));
      chk("strobe", 36'(ex[0]), 36'(dqs_o[0]));
      chk("strobe n", 36'(!ex[0]), 36'(dqs_n_o[0]));
      chk("odt static", 36'h3, 36'({dq_odt_o[0], dqs_odt_o[0]}));
    end
    wr(la(0), 32'h7C00_4E87, rs);
    repeat (2) @(negedge clk_i);
    chk("odt idle", 36'h0, 36'({dq_odt_o[0], dqs_odt_o[0]}));
    @(posedge clk_i);
    rd_ahead_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk("odt read", 36'h3, 36'({dq_odt_o[0], dqs_odt_o[0]}));
    @(posedge clk_i);
    rd_ahead_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk("odt hold", 36'h3, 36'({dq_odt_o[0], dqs_odt_o[0]}));
    repeat (1) @(negedge clk_i);
    chk("odt off", 36'h0, 36'({dq_odt_o[0], dqs_odt_o[0]}));
    $display("Pin test done");
    wrap_up();
  end
endmodule
`default_nettype wire

// *** sim/ddr_sdram_model.sv ***
`default_nettype none
// =====
// Write-level responses from the memory ranks
module ddr_sdram_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Responses per lane and rank
  output logic [8:0][3:0] wl_resp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  // Pattern moves every cycle, so a stale level never passes for a response
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h7;
    end
  end
  assign wl_resp_o = {9{cnt_r}};
endmodule
`default_nettype wire

// *** verilog/ddr_phy_lane_regs.sv ***
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module ddr_phy_lane_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Impedance calibration blocks
  input wire logic [3:0] imp_cal_complete_i,
  input wire logic [3:0] imp_cal_fault_i,
  input wire logic [3:0][27:0] imp_code_current_i,
  input wire logic [3:0][7:0] imp_cal_state_i,
  output logic [3:0][6:0] term_pullup_sel_o,
  output logic [3:0][6:0] term_pulldown_sel_o,
  output logic [3:0][6:0] drv_pullup_sel_o,
  output logic [3:0][6:0] drv_pulldown_sel_o,
  // PHY sequencing and DFI timing
  input wire logic phy_init_done_i,
  input wire logic rd_ahead_i,
  input wire logic wr_oe_i,
  input wire logic wr_strobe_phase_i,
  input wire logic [8:0][3:0] wl_resp_i,
  // Per byte lane outputs
  output logic [8:0] lane_cal_start_o,
  output logic [8:0] master_delay_line_track_o,
  output logic [8:0][3:0] wl_resp_used_o,
  output logic [8:0][3:0] wl_rank_done_o,
  output logic [8:0] lane_pll_bypass_o,
  output logic [8:0] lane_pll_fast_lock_o,
  output logic [8:0] lane_pll_powerdown_o,
  output logic [8:0] lane_pll_reset_o,
  output logic [8:0] dq_oe_o,
  output logic [8:0] dqs_o,
  output logic [8:0] dqs_n_o,
  output logic [8:0] dqs_oe_o,
  output logic [8:0] dq_odt_o,
  output logic [8:0] dqs_odt_o,
  output logic [8:0] strobe_rx_cell_powerdown_o,
  output logic [8:0] lane_receiver_powerdown_o,
  output logic [8:0] lane_driver_powerdown_o,
  output logic [8:0] lane_cmos_io_select_o,
  output logic [8:0] byte_lane_enable_o
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [8:0][31:0] gcr;
    logic [3:0] glob;
    logic [3:0][31:0] zq_main;
    logic [3:0][7:0] zq_detail;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic rd_d1;
    logic rd_d2;
    logic [8:0][1:0] hold_cnt;
    logic [8:0] cal_start;
    logic [8:0] dq_oe;
    logic [8:0] dqs;
    logic [8:0] dq_odt;
    logic [8:0] dqs_odt;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Returns {error, word}
  function automatic logic [32:0] read_word(input logic [7:0] addr, input state_t st);
    logic [32:0] res;
    res = {1'b1, 32'h0000_0000};
    for (int i = 0; i < ddr_phy_lane_pkg::IMP_INST; i++) begin
      if (addr[7:2] == 6'((ddr_phy_lane_pkg::ZQ_MAIN_OFS + 8'(i) * ddr_phy_lane_pkg::ZQ_STRIDE)
                          >> 2)) begin
        res = {1'b0, st.zq_main[i]};
      end
      if (addr[7:2] == 6'((ddr_phy_lane_pkg::ZQ_DETAIL_OFS + 8'(i) * ddr_phy_lane_pkg::ZQ_STRIDE)
                          >> 2)) begin
        res = {1'b0, 24'h00_0000, st.zq_detail[i]};
      end
    end
    for (int i = 0; i < ddr_phy_lane_pkg::LANE_NUM; i++) begin
      if (addr[7:2] == 6'((ddr_phy_lane_pkg::LANE_OFS >> 2) + 8'(i))) begin
        res = {1'b0, st.gcr[i]};
      end
    end
    if (addr[7:2] == ddr_phy_lane_pkg::GLOB_OFS[7:2]) begin
      res = {1'b0, 28'h000_0000, st.glob};
    end
    return res;
  endfunction

  logic [32:0] rd_word;
  logic early_src;
  logic odt_win;
  logic [32:0] wr_word;
  logic [31:0] glob_word;

  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign rd_word = read_word(s_axi_araddr, s_r);
  assign wr_word = read_word(s_r.aw_addr, s_r);
  assign glob_word = merge_strb({28'h000_0000, s_r.glob}, s_r.w_data, s_r.w_strb);

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    early_src = 1'b0;
    odt_win = 1'b0;
    // Bus write
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_word[32] ? ddr_phy_lane_pkg::RESP_SLVERR : ddr_phy_lane_pkg::RESP_OKAY;
      for (int i = 0; i < ddr_phy_lane_pkg::LANE_NUM; i++) begin
        if (s_r.aw_addr[7:2] == 6'((ddr_phy_lane_pkg::LANE_OFS >> 2) + 8'(i))) begin
          s_nxt.gcr[i] = merge_strb(s_r.gcr[i], s_r.w_data, s_r.w_strb)
                         & ddr_phy_lane_pkg::GCR_WMASK;
        end
      end
      if (s_r.aw_addr[7:2] == ddr_phy_lane_pkg::GLOB_OFS[7:2]) begin
        s_nxt.glob = glob_word[3:0];
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Bus read
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_word[31:0];
      s_nxt.rresp = rd_word[32] ? ddr_phy_lane_pkg::RESP_SLVERR : ddr_phy_lane_pkg::RESP_OKAY;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // Impedance status capture, reserved bits forced to zero
    for (int i = 0; i < ddr_phy_lane_pkg::IMP_INST; i++) begin
      s_nxt.zq_main[i] = {imp_cal_complete_i[i], imp_cal_fault_i[i], 2'b00,
                          imp_code_current_i[i]};
      s_nxt.zq_detail[i] = imp_cal_state_i[i];
    end
    // Read window delay line
    s_nxt.rd_d1 = rd_ahead_i;
    s_nxt.rd_d2 = s_r.rd_d1;
    for (int l = 0; l < ddr_phy_lane_pkg::LANE_NUM; l++) begin
      // Early or late start of read termination
      early_src = s_r.gcr[l][ddr_phy_lane_pkg::EARLY_BIT] ? s_r.rd_d1 : rd_ahead_i;
      if (s_r.rd_d2) begin
        s_nxt.hold_cnt[l] = s_r.gcr[l][ddr_phy_lane_pkg::HOLD_LSB +: 2];
      end else if (s_r.hold_cnt[l] != 2'd0) begin
        s_nxt.hold_cnt[l] = s_r.hold_cnt[l] - 2'd1;
      end
      odt_win = early_src || s_r.rd_d1 || s_r.rd_d2 || (s_r.hold_cnt[l] != 2'd0);
      s_nxt.dq_odt[l] = s_r.gcr[l][ddr_phy_lane_pkg::DATA_TERMINATION_ENABLE_BIT]
                        && (odt_win || !s_r.gcr[l][ddr_phy_lane_pkg::DQDYN_BIT]);
      s_nxt.dqs_odt[l] = s_r.gcr[l][ddr_phy_lane_pkg::STROBE_TERMINATION_ENABLE_BIT]
                         && (odt_win || !s_r.gcr[l][ddr_phy_lane_pkg::DQSDYN_BIT]);
      // Output enable override, disabled lanes never drive
      case (s_r.gcr[l][ddr_phy_lane_pkg::OEO_LSB +: 2])
        ddr_phy_lane_pkg::OEO_OUT: s_nxt.dq_oe[l] = 1'b1;
        ddr_phy_lane_pkg::OEO_IN: s_nxt.dq_oe[l] = 1'b0;
        default: s_nxt.dq_oe[l] = wr_oe_i;
      endcase
      if (!s_r.gcr[l][ddr_phy_lane_pkg::EN_BIT]) begin
        s_nxt.dq_oe[l] = 1'b0;
      end
      // Write strobe shape
      case (s_r.gcr[l][ddr_phy_lane_pkg::STRB_LSB +: 2])
        ddr_phy_lane_pkg::STRB_LOW: s_nxt.dqs[l] = 1'b0;
        ddr_phy_lane_pkg::STRB_NORM: s_nxt.dqs[l] = wr_strobe_phase_i;
        ddr_phy_lane_pkg::STRB_INV: s_nxt.dqs[l] = !wr_strobe_phase_i;
        default: s_nxt.dqs[l] = 1'b1;
      endcase
      // Automatic period calibration after init
      s_nxt.cal_start[l] = phy_init_done_i && !s_r.gcr[l][ddr_phy_lane_pkg::SKIP_BIT]
                           && s_r.gcr[l][ddr_phy_lane_pkg::EN_BIT];
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.glob <= ddr_phy_lane_pkg::GLOB_RST;
      for (int l = 0; l < ddr_phy_lane_pkg::LANE_NUM; l++) begin
        s_r.gcr[l] <= ddr_phy_lane_pkg::GCR_RST;
      end
      for (int i = 0; i < ddr_phy_lane_pkg::IMP_INST; i++) begin
        s_r.zq_main[i] <= ddr_phy_lane_pkg::ZQ_MAIN_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;

  always_comb begin
    for (int i = 0; i < ddr_phy_lane_pkg::IMP_INST; i++) begin
      term_pullup_sel_o[i] = s_r.zq_main[i][ddr_phy_lane_pkg::TPU_LSB +: 7];
      term_pulldown_sel_o[i] = s_r.zq_main[i][ddr_phy_lane_pkg::TPD_LSB +: 7];
      drv_pullup_sel_o[i] = s_r.zq_main[i][ddr_phy_lane_pkg::DPU_LSB +: 7];
      drv_pulldown_sel_o[i] = s_r.zq_main[i][ddr_phy_lane_pkg::DPD_LSB +: 7];
    end
  end

  always_comb begin
    for (int l = 0; l < ddr_phy_lane_pkg::LANE_NUM; l++) begin
      master_delay_line_track_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::TRACK_BIT]
                                     && s_r.glob[ddr_phy_lane_pkg::G_MDL_BIT];
      wl_resp_used_o[l] = wl_resp_i[l] & s_r.gcr[l][ddr_phy_lane_pkg::WLM_LSB +: 4];
      wl_rank_done_o[l] = ~s_r.gcr[l][ddr_phy_lane_pkg::WLM_LSB +: 4];
      lane_pll_bypass_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::BYP_BIT]
                             || s_r.glob[ddr_phy_lane_pkg::G_BYP_BIT];
      lane_pll_fast_lock_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::FAST_BIT];
      lane_pll_powerdown_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::PD_BIT]
                                || s_r.glob[ddr_phy_lane_pkg::G_PD_BIT];
      lane_pll_reset_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::RST_BIT]
                            || s_r.glob[ddr_phy_lane_pkg::G_RST_BIT];
      strobe_rx_cell_powerdown_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::RXCELL_BIT];
      lane_receiver_powerdown_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::RXPD_BIT];
      lane_driver_powerdown_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::DRVPD_BIT];
      lane_cmos_io_select_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::CMOS_BIT];
      byte_lane_enable_o[l] = s_r.gcr[l][ddr_phy_lane_pkg::EN_BIT];
    end
  end

  assign lane_cal_start_o = s_r.cal_start;
  assign dq_oe_o = s_r.dq_oe;
  assign dqs_oe_o = s_r.dq_oe;
  assign dqs_o = s_r.dqs;
  assign dqs_n_o = ~s_r.dqs;
  assign dq_odt_o = s_r.dq_odt;
  assign dqs_odt_o = s_r.dqs_odt;

  // ==========================================================
  // Checks
  property p_cal_complete;
    @(posedge clk_i) disable iff (!rst_n_i)
      rst_n_i && imp_cal_complete_i[1] |=> s_r.zq_main[1][31];
  endproperty
  a_cal_complete: assert property (p_cal_complete)
    else $error("complete flag not captured");

  property p_cal_fault;
    @(posedge clk_i) disable iff (!rst_n_i)
      rst_n_i && imp_cal_fault_i[1] |=> s_r.zq_main[1][30];
  endproperty
  a_cal_fault: assert property (p_cal_fault)
    else $error("fault flag not captured");

  property p_code;
    @(posedge clk_i) disable iff (!rst_n_i)
      rst_n_i |=> drv_pulldown_sel_o[2] == $past(imp_code_current_i[2][6:0])
          && term_pullup_sel_o[2] == $past(imp_code_current_i[2][27:21]);
  endproperty
  a_code: assert property (p_code)
    else $error("code select mismatch");

  property p_skip_cal;
    @(posedge clk_i) disable iff (!rst_n_i)
      phy_init_done_i && s_r.gcr[1][31] |=> !lane_cal_start_o[1];
  endproperty
  a_skip_cal: assert property (p_skip_cal)
    else $error("calibration started despite skip");

  property p_track;
    @(posedge clk_i) disable iff (!rst_n_i)
      !s_r.glob[3] |-> master_delay_line_track_o == 9'h000;
  endproperty
  a_track: assert property (p_track)
    else $error("tracking without common enable");

  property p_oe_force;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_r.gcr[0][15:14] == 2'h1 && s_r.gcr[0][0] |=> dq_oe_o[0] && dqs_oe_o[0];
  endproperty
  a_oe_force: assert property (p_oe_force)
    else $error("forced output not driven");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      (s_r.rd_d2 && !s_r.rd_d1 && !rd_ahead_i && s_r.gcr[0][12:11] == 2'h1
       && s_r.gcr[0][10] && s_r.gcr[0][2] ##1 !rd_ahead_i [*2])
      |-> dq_odt_o[0] ##1 !dq_odt_o[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("termination hold length wrong");

  property p_strobe_high;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_r.gcr[0][8:7] == 2'h3 |=> dqs_o[0] && !dqs_n_o[0];
  endproperty
  a_strobe_high: assert property (p_strobe_high)
    else $error("strobe not held high");

  property p_lane_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      !s_r.gcr[4][0] |=> !dq_oe_o[4] && !lane_cal_start_o[4];
  endproperty
  a_lane_off: assert property (p_lane_off)
    else $error("disabled lane active");

  property p_wl_mask;
    @(posedge clk_i) disable iff (!rst_n_i)
      !s_r.gcr[2][27] |-> wl_rank_done_o[2][1] && !wl_resp_used_o[2][1];
  endproperty
  a_wl_mask: assert property (p_wl_mask)
    else $error("masked rank not ignored");

endmodule
`default_nettype wire
